/* hw/tef_pkg.sv */
/*
  tef_pkg: offsets, field positions, reset values and encodings for the
  trace entry formatter. Assumes a 32-bit APB register bus.
*/
package tef_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] TEF_CTRL_OFS = 8'h00;
  localparam logic [7:0] TEF_STAT_OFS = 8'h04;
  localparam logic [7:0] TEF_PAGE_OFS = 8'h08;
  // control fields
  localparam int TEF_CTRL_EN_BIT = 0;
  localparam int TEF_CTRL_PC_BIT = 1;
  localparam int TEF_CTRL_AL_LSB = 2;
  localparam logic [3:0] TEF_CTRL_RST = 4'h0;
  // ---------------------------------------------------------------
  // information byte layout
  // ---------------------------------------------------------------
  localparam int TEF_SIZE_MSB = 7;
  localparam int TEF_SIZE_LSB = 6;
  localparam int TEF_RW_BIT = 5;
  localparam int TEF_CMP_BIT = 3;
  localparam int TEF_PCV_BIT = 2;
  localparam int TEF_MARK_BIT = 1;
  localparam int TEF_WRAP_BIT = 0;
  localparam int TEF_INFO_LSB = 24;
  localparam int TEF_MAT_BIT = 63;
  localparam int TEF_LINE_W = 64;
  localparam int TEF_PAY_BYTES = 7;
  // line counter steps
  localparam logic [3:0] TEF_STEP_ONE = 4'h2;
  localparam logic [3:0] TEF_STEP_TWO = 4'h4;
  // compressed entries fit while the base still fits behind them
  localparam logic [2:0] TEF_LAST_CMP_POS = 3'h3;
  localparam logic [2:0] TEF_BASE_LEN = 3'h3;
  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TEF_AL_BEGIN = 2'b00,
    TEF_AL_MID = 2'b01,
    TEF_AL_END = 2'b10
  } tef_align_t;
  typedef enum logic [1:0] {
    TEF_SZ_8 = 2'b00,
    TEF_SZ_16 = 2'b01,
    TEF_SZ_24 = 2'b10,
    TEF_SZ_32 = 2'b11
  } tef_size_t;
endpackage : tef_pkg

/* hw/tef_trace_entry_formatter.sv */
/*
  tef_trace_entry_formatter: builds 64-bit trace buffer lines from CPU
  activity in detail mode and program-counter-only mode, with an APB
  register slave. Assumes CPU strobes are synchronous to pclk and that
  the trace RAM accepts one line per cycle with no back-pressure.
*/
// How it works
// [RL1] access size sits in access byte bits 7:6
// [RL2] access byte bit 5 set for reads
// [RL3] stamp byte always has bit 1 set
// [RL4] stamp bit 3 marks comparator D entries
// [RL5] stamp bit 2 only with valid PC
// [RL6] stamp bit 0 marks stamp counter wrap
// [RL7] every executed opcode PC is recorded
// [RL8] same 256-byte page stores low byte only
// [RL9] full PC closes each record
// [RL10] seven payload bytes plus top info byte
// [RL11] fill upward, line ends with base
// [RL12] base normally lands in bytes 6 to 4
// [RL13] earlier base leaves upper bytes unused
// [RL14] info bits 6:4 count valid payload bytes
// [RL15] marker set on base low byte only
// [RL16] mid trigger flags line, starts new line
// [RL17] flag meaningless in begin/end alignment
// [RL18] trigger with new PC keeps it on line
// [RL19] no stamp or event lines in PC mode
// [RL20] counter adds four for paired lines, else two
// [RL21] info byte: flag, count, markers 3:0
// [RL22] unused info bits written as zero
`timescale 1ns/100ps
module tef_trace_entry_formatter
  import tef_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_valid,
  input wire logic acc_read,
  input wire logic [1:0] acc_size,
  input wire logic [23:0] acc_addr,
  input wire logic [31:0] acc_data,
  input wire logic stamp_valid,
  input wire logic [15:0] stamp_value,
  input wire logic stamp_cmp_d,
  input wire logic stamp_wrap,
  input wire logic stamp_pc_valid,
  input wire logic [23:0] stamp_pc,
  input wire logic exec_valid,
  input wire logic [23:0] exec_pc,
  input wire logic event_fired_flag,
  output logic line_valid,
  output logic [63:0] line_data,
  output logic [CNT_W-1:0] line_count_field
);
  // ---------------------------------------------------------------
  // registers and apb slave
  // ---------------------------------------------------------------
  logic [3:0] ctrl_reg;
  logic en_d_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [3:0] cnt_add;
  logic acc_phase;
  logic hit;
  logic en;
  logic pc_mode;
  logic det_go;
  logic pc_go;
  logic mid_fire;
  logic [23:0] held_reg;
  logic held_v_reg;
  logic [2:0] pos_reg;
  logic [55:0] pay_reg;
  logic [6:0] nb_reg;
  logic mat_pend_reg;

  assign en = ctrl_reg[TEF_CTRL_EN_BIT];
  assign pc_mode = ctrl_reg[TEF_CTRL_PC_BIT];
  assign det_go = en && !pc_mode;
  assign pc_go = en && pc_mode;
  // the flag means nothing unless mid alignment is chosen
  assign mid_fire = event_fired_flag &&
      (ctrl_reg[TEF_CTRL_AL_LSB+:2] == TEF_AL_MID); // [RL17]
  assign acc_phase = psel && penable && pready_reg;
  assign hit = (paddr == TEF_CTRL_OFS) || (paddr == TEF_STAT_OFS) ||
      (paddr == TEF_PAGE_OFS);

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !hit;
      if (psel && penable && !pready_reg && !pwrite) begin
        case (paddr)
          TEF_CTRL_OFS: prdata_reg <= {28'h0000000, ctrl_reg};
          TEF_STAT_OFS: prdata_reg <= 32'(cnt_reg);
          TEF_PAGE_OFS: prdata_reg <= {4'h0, pos_reg, held_v_reg, held_reg};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // control register; only writes to its own address land
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= TEF_CTRL_RST;
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= en;
      if (acc_phase && pwrite && paddr == TEF_CTRL_OFS) begin
        ctrl_reg <= pwdata[3:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // detail mode lines
  // ---------------------------------------------------------------
  logic [7:0] acc_info;
  logic [7:0] stamp_info;
  logic [63:0] acc_line;
  logic [63:0] stamp_line;
  logic spend_reg;
  logic [63:0] spend_line_reg;

  always_comb begin
    acc_info = 8'h00; // [RL22]
    acc_info[TEF_SIZE_MSB:TEF_SIZE_LSB] = acc_size; // [RL1]
    acc_info[TEF_RW_BIT] = acc_read; // [RL2]
    stamp_info = 8'h00; // [RL22]
    stamp_info[TEF_CMP_BIT] = stamp_cmp_d; // [RL4]
    stamp_info[TEF_PCV_BIT] = stamp_pc_valid; // [RL5]
    stamp_info[TEF_MARK_BIT] = 1'b1; // [RL3]
    stamp_info[TEF_WRAP_BIT] = stamp_wrap; // [RL6]
    acc_line = {acc_data, acc_info, acc_addr};
    stamp_line = {stamp_value, 16'h0000, stamp_info,
        stamp_pc_valid ? stamp_pc : 24'h000000};
  end

  // ---------------------------------------------------------------
  // pc-only packing
  // ---------------------------------------------------------------
  logic pc_emit;
  logic [63:0] pc_line;
  logic [23:0] held_next;
  logic held_v_next;
  logic [2:0] pos_next;
  logic [55:0] pay_next;
  logic [6:0] nb_next;
  logic mat_pend_next;
  logic [55:0] pay_w;
  logic [6:0] nb_w;
  logic [2:0] cnt_w;
  logic do_close;
  logic put_base;
  logic mat_w;
  logic stop;

  // a base must still fit behind each compressed byte, so the line
  // closes early on a page change and leaves the top bytes unused
  always_comb begin
    held_next = held_reg;
    held_v_next = held_v_reg;
    pos_next = pos_reg;
    pay_next = pay_reg;
    nb_next = nb_reg;
    mat_pend_next = mat_pend_reg;
    pay_w = pay_reg;
    nb_w = nb_reg;
    do_close = 1'b0;
    put_base = 1'b0;
    mat_w = 1'b0;
    stop = en_d_reg && !en && pc_mode;
    if (pc_go && exec_valid) begin // [RL7]
      held_next = exec_pc;
      held_v_next = 1'b1;
      mat_pend_next = mid_fire; // [RL18]
      if (held_v_reg && held_reg[23:8] == exec_pc[23:8] && !mat_pend_reg &&
          pos_reg <= TEF_LAST_CMP_POS) begin
        pay_next[pos_reg*8+:8] = held_reg[7:0]; // [RL8]
        pos_next = pos_reg + 3'h1;
      end else if (held_v_reg) begin
        put_base = 1'b1; // [RL9]
        do_close = 1'b1;
        mat_w = mat_pend_reg;
      end
    end else if ((pc_go && (mid_fire || mat_pend_reg)) || stop) begin
      // flush now so the next entry opens a new line at byte 0
      put_base = held_v_reg; // [RL16]
      do_close = held_v_reg || (pos_reg != 3'h0);
      mat_w = mid_fire || mat_pend_reg;
      held_v_next = 1'b0;
      mat_pend_next = 1'b0;
    end
    if (put_base) begin
      pay_w[pos_reg*8+:8] = held_reg[7:0]; // [RL12] [RL13]
      pay_w[(pos_reg+3'h1)*8+:8] = held_reg[15:8];
      pay_w[(pos_reg+3'h2)*8+:8] = held_reg[23:16];
      nb_w[pos_reg] = 1'b1; // [RL15]
    end
    cnt_w = put_base ? pos_reg + TEF_BASE_LEN : pos_reg; // [RL14]
    pc_line = {mat_w, cnt_w, nb_w[3:0], pay_w}; // [RL10] [RL21]
    pc_emit = do_close;
    if (do_close) begin
      pos_next = 3'h0; // [RL11]
      pay_next = 56'h0;
      nb_next = 7'h00;
    end
  end

  // packing state; a close and the next pc land in the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_reg <= 24'h000000;
      held_v_reg <= 1'b0;
      pos_reg <= 3'h0;
      pay_reg <= 56'h0;
      nb_reg <= 7'h00;
      mat_pend_reg <= 1'b0;
    end else begin
      held_reg <= held_next;
      held_v_reg <= held_v_next;
      pos_reg <= pos_next;
      pay_reg <= pay_next;
      nb_reg <= nb_next;
      mat_pend_reg <= mat_pend_next;
    end
  end

  // ---------------------------------------------------------------
  // line output and line counter
  // ---------------------------------------------------------------
  // an access wins the port; its stamp line waits for the first cycle without an access, and a
  // second stamp while one waits is dropped, or replaces the waiting one if it comes with an access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_valid <= 1'b0;
      line_data <= 64'h0;
      spend_reg <= 1'b0;
      spend_line_reg <= 64'h0;
    end else begin
      line_valid <= 1'b0;
      if (det_go && acc_valid) begin
        line_valid <= 1'b1;
        line_data <= acc_line;
        if (stamp_valid) begin
          spend_reg <= 1'b1;
          spend_line_reg <= stamp_line;
        end
      end else if (det_go && spend_reg) begin
        line_valid <= 1'b1;
        line_data <= spend_line_reg;
        spend_reg <= 1'b0;
      end else if (det_go && stamp_valid) begin
        line_valid <= 1'b1;
        line_data <= stamp_line;
      end else if (pc_emit) begin // [RL19]
        line_valid <= 1'b1;
        line_data <= pc_line;
      end
      if (!det_go) begin
        spend_reg <= 1'b0;
      end
    end
  end

  // a paired entry is counted at its access edge, so the deferred stamp adds nothing
  always_comb begin
    cnt_add = 4'h0;
    if (det_go && acc_valid) begin
      cnt_add = stamp_valid ? TEF_STEP_TWO : TEF_STEP_ONE; // [RL20]
    end else if (det_go && spend_reg) begin
      cnt_add = 4'h0;
    end else if ((det_go && stamp_valid) || pc_emit) begin
      cnt_add = TEF_STEP_ONE;
    end
  end

  // restarts whenever tracing is switched on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      line_count_field <= '0;
    end else begin
      if (en && !en_d_reg) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + CNT_W'(cnt_add);
      end
      line_count_field <= cnt_reg;
    end
  end

  // bus outputs come straight from their flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_access_size: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
    det_go && acc_valid |=> line_valid && line_data[31:30] == $past(acc_size))
    else $error("access size field wrong");
  a_access_dir: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
    det_go && acc_valid |=> line_data[29] == $past(acc_read) &&
        line_data[28:24] == 5'h00)
    else $error("read write flag wrong");
  a_stamp_mark: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
    det_go && stamp_valid && !acc_valid && !spend_reg |=>
        line_valid && line_data[25] && line_data[31:28] == 4'h0)
    else $error("stamp line not marked");
  a_stamp_cmp: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
    det_go && stamp_valid && acc_valid ##1 det_go && !acc_valid |=>
        line_valid && line_data[27] == $past(stamp_cmp_d, 2))
    else $error("comparator flag wrong");
  a_stamp_pcv: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
    det_go && stamp_valid && !acc_valid && !spend_reg && !stamp_pc_valid |=>
        !line_data[26] && line_data[23:0] == 24'h000000)
    else $error("pc valid flag wrong");
  a_stamp_wrap: assert property (@(posedge pclk) disable iff (!presetn) // [RL6]
    det_go && stamp_valid && !acc_valid && !spend_reg |=>
        line_data[24] == $past(stamp_wrap))
    else $error("wrap flag wrong");
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn) // [RL20]
    det_go && en_d_reg && acc_valid && stamp_valid |=>
        cnt_reg == $past(cnt_reg) + CNT_W'(4))
    else $error("line count not advanced by four");
  a_pc_count: assert property (@(posedge pclk) disable iff (!presetn) // [RL14]
    pc_emit |=> line_valid && line_data[62:60] != 3'h0 && pos_reg == 3'h0)
    else $error("pc line count or restart wrong");
  a_pc_base_fit: assert property (@(posedge pclk) disable iff (!presetn) // [RL13]
    pos_reg <= 3'h4)
    else $error("base cannot fit on line");
  a_pc_no_stamp: assert property (@(posedge pclk) disable iff (!presetn) // [RL19]
    pc_go && !pc_emit |=> !line_valid)
    else $error("stray line in pc mode");
  // pc-only checks look at the registered line one cycle on
  a_pc_full_line: assert property (@(posedge pclk) disable iff (!presetn) // [RL12]
    pc_emit && pos_reg == 3'h4 |=> line_data[62:60] == 3'h7 && line_data[59:56] == 4'h0)
    else $error("full line layout wrong");
  a_pc_marker: assert property (@(posedge pclk) disable iff (!presetn) // [RL15]
    pc_emit && held_v_reg && pos_reg == 3'h0 |=> line_data[56] && line_data[62:60] == 3'h3)
    else $error("base marker wrong");
  a_pc_mid_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RL16]
    pc_go && !exec_valid && mid_fire && held_v_reg |=> line_valid && line_data[63])
    else $error("mid trigger flag missing");
  a_pc_compress: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
    pc_go && exec_valid && held_v_reg && !mat_pend_reg && pos_reg <= 3'h3 &&
        held_reg[23:8] == exec_pc[23:8] |=> !line_valid && pos_reg == $past(pos_reg) + 3'h1)
    else $error("same page pc not compressed");
  a_stamp_pc_carry: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
    det_go && stamp_valid && !acc_valid && !spend_reg && stamp_pc_valid |=>
        line_data[26] && line_data[23:0] == $past(stamp_pc))
    else $error("stamp pc not carried");
endmodule : tef_trace_entry_formatter

/* sim/tef_cpu_model.sv */
/*
  tef_cpu_model: behavioural cpu execute and data access stages that feed
  the trace formatter. Assumes the caller enters each task right after a
  rising pclk edge, and closes every burst with idle.
*/
`timescale 1ns/100ps
module tef_cpu_model (
  input wire logic pclk,
  output logic acc_valid,
  output logic acc_read,
  output logic [1:0] acc_size,
  output logic [23:0] acc_addr,
  output logic [31:0] acc_data,
  output logic stamp_valid,
  output logic [15:0] stamp_value,
  output logic stamp_cmp_d,
  output logic stamp_wrap,
  output logic stamp_pc_valid,
  output logic [23:0] stamp_pc,
  output logic exec_valid,
  output logic [23:0] exec_pc
);
  // ---------------------------------------------------------------
  // strobes and buses
  // ---------------------------------------------------------------
  // quiet at time zero
  initial begin
    {acc_valid, acc_read, acc_size, acc_addr, acc_data} = '0;
    {stamp_valid, stamp_value, stamp_cmp_d, stamp_wrap} = '0;
    {stamp_pc_valid, stamp_pc, exec_valid, exec_pc} = '0;
  end
  // one data access this cycle
  task acc(input logic rd, input logic [1:0] sz, input logic [23:0] a, input logic [31:0] d);
    acc_valid <= 1'b1;
    acc_read <= rd;
    acc_size <= sz;
    acc_addr <= a;
    acc_data <= d;
  endtask : acc
  // stamp request, flags are comparator d, pc valid, wrap
  task stamp(input logic [2:0] f, input logic [23:0] pc, input logic [15:0] ts);
    stamp_valid <= 1'b1;
    {stamp_cmp_d, stamp_pc_valid, stamp_wrap} <= f;
    stamp_pc <= pc;
    stamp_value <= ts;
  endtask : stamp
  // every opcode entering execute, illegal ones too
  task exec(input logic [23:0] pc);
    exec_valid <= 1'b1;
    exec_pc <= pc;
  endtask : exec
  // address, data and pc buses invert when idle so a stale value there can never pass for a fresh one
  task idle;
    @(posedge pclk);
    {acc_valid, stamp_valid, exec_valid} <= 3'h0;
    acc_addr <= ~acc_addr;
    acc_data <= ~acc_data;
    stamp_pc <= ~stamp_pc;
    exec_pc <= ~exec_pc;
  endtask : idle
endmodule : tef_cpu_model

/* sim/tef_trace_entry_formatter_tb.sv */
/*
  tef_trace_entry_formatter_tb: self-checking bench for detail and pc-only
  lines and the apb registers. Assumes one apb wait state at most 20 cycles.
*/
`timescale 1ns/100ps
module tef_trace_entry_formatter_tb;
  import tef_pkg::*;
  typedef struct packed {
    logic k; logic rd; logic [1:0] sz; logic [2:0] f;
    logic [23:0] a; logic [31:0] d; logic [63:0] e;
  } tef_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q32;
  logic pready, pslverr, err, fire = 1'b0, line_valid, seen;
  logic acc_valid, acc_read, stamp_valid, stamp_cmp_d, stamp_wrap, stamp_pc_valid, exec_valid;
  logic [1:0] acc_size;
  logic [23:0] acc_addr, stamp_pc, exec_pc;
  logic [31:0] acc_data;
  logic [15:0] stamp_value, line_count_field;
  logic [63:0] line_data, q64;
  int n_errors = 0, n_tests = 0;
  logic [23:0] pcs [6] = '{24'h001200, 24'h001204, 24'h001208, 24'h001210, 24'h001214, 24'h003000};
  tef_row_t rows [6] = '{
    '{1'b0, 1'b1, 2'b00, 3'h0, 24'h000101, 32'h11000000, 64'h11000000_20_000101},
    '{1'b0, 1'b0, 2'b01, 3'h0, 24'h00a002, 32'h22330000, 64'h22330000_40_00a002},
    '{1'b0, 1'b1, 2'b10, 3'h0, 24'h7ffff0, 32'h44556600, 64'h44556600_a0_7ffff0},
    '{1'b0, 1'b0, 2'b11, 3'h0, 24'hfffffc, 32'h8899aabb, 64'h8899aabb_c0_fffffc},
    '{1'b1, 1'b0, 2'b00, 3'h6, 24'h123456, 32'h0000beef, 64'hbeef0000_0e_123456},
    '{1'b1, 1'b0, 2'b00, 3'h1, 24'h654321, 32'h0000ffff, 64'hffff0000_03_000000}};
  // ---------------------------------------------------------------
  // design and cpu model
  // ---------------------------------------------------------------
  tef_trace_entry_formatter #(.CNT_W(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .acc_valid(acc_valid), .acc_read(acc_read),
    .acc_size(acc_size), .acc_addr(acc_addr), .acc_data(acc_data), .stamp_valid(stamp_valid),
    .stamp_value(stamp_value), .stamp_cmp_d(stamp_cmp_d), .stamp_wrap(stamp_wrap),
    .stamp_pc_valid(stamp_pc_valid), .stamp_pc(stamp_pc), .exec_valid(exec_valid),
    .exec_pc(exec_pc), .event_fired_flag(fire), .line_valid(line_valid),
    .line_data(line_data), .line_count_field(line_count_field));
  tef_cpu_model cpu (.pclk(pclk), .acc_valid(acc_valid), .acc_read(acc_read),
    .acc_size(acc_size), .acc_addr(acc_addr), .acc_data(acc_data), .stamp_valid(stamp_valid),
    .stamp_value(stamp_value), .stamp_cmp_d(stamp_cmp_d), .stamp_wrap(stamp_wrap),
    .stamp_pc_valid(stamp_pc_valid), .stamp_pc(stamp_pc), .exec_valid(exec_valid),
    .exec_pc(exec_pc));
  // 100 MHz clock
  initial begin
    forever #5 pclk = ~pclk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task end_of_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // the request stands until pready is seen high at a rising edge; data is taken there
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_errors++;
      end_of_test();
    end
    q32 = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task wait_line;
    int i;
    for (i = 0; i < 8; i++) begin
      @(negedge pclk);
      if (line_valid === 1'b1) begin
        q64 = line_data;
        return;
      end
    end
    n_errors++;
    end_of_test();
  endtask : wait_line
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({line_valid, line_count_field}, 64'h0);
    apb(1'b0, TEF_CTRL_OFS, 32'h0);
    chk(q32, 64'h0);
    apb(1'b1, TEF_CTRL_OFS, 32'h1);
    foreach (rows[i]) begin
      @(posedge pclk);
      if (rows[i].k) cpu.stamp(rows[i].f, rows[i].a, rows[i].d[15:0]);
      else cpu.acc(rows[i].rd, rows[i].sz, rows[i].a, rows[i].d);
      cpu.idle();
      wait_line();
      chk(q64, rows[i].e);
    end
    apb(1'b0, TEF_STAT_OFS, 32'h0);
    chk(q32, 64'hc);
    // access and stamp together take two lines and a step of four
    @(posedge pclk);
    cpu.acc(1'b1, 2'b11, 24'h000200, 32'h01020304);
    cpu.stamp(3'h2, 24'h000300, 16'h0005);
    cpu.idle();
    wait_line();
    chk(q64, 64'h01020304_e0_000200);
    wait_line();
    chk(q64, 64'h00050000_06_000300);
    apb(1'b0, TEF_STAT_OFS, 32'h0);
    chk(q32, 64'h10);
    // pc-only with mid alignment; re-enabling clears the counter
    apb(1'b1, TEF_CTRL_OFS, 32'h0);
    apb(1'b1, TEF_CTRL_OFS, 32'h7);
    @(posedge pclk);
    cpu.stamp(3'h7, 24'h000400, 16'h0009);
    cpu.idle();
    seen = 1'b0;
    repeat (6) @(negedge pclk) if (line_valid === 1'b1) seen = 1'b1;
    chk(seen, 64'h0);
    foreach (pcs[i]) begin
      @(posedge pclk);
      cpu.exec(pcs[i]);
    end
    cpu.idle();
    wait_line();
    chk(q64, 64'h70001214_10080400);
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    wait_line();
    chk({q64[63:56], q64[23:0]}, {8'hb1, 24'h003000});
    apb(1'b0, TEF_STAT_OFS, 32'h0);
    chk(q32, 64'h4);
    // trigger in the cycle of a new pc keeps that pc on the flagged line
    @(posedge pclk);
    cpu.exec(24'h003010);
    fire <= 1'b1;
    cpu.idle();
    fire <= 1'b0;
    wait_line();
    chk({q64[63:56], q64[23:0]}, {8'hb1, 24'h003010});
    // with end alignment the trigger starts no line
    apb(1'b1, TEF_CTRL_OFS, 32'hb);
    @(posedge pclk);
    cpu.exec(24'h004000);
    fire <= 1'b1;
    cpu.idle();
    fire <= 1'b0;
    seen = 1'b0;
    repeat (6) @(negedge pclk) if (line_valid === 1'b1) seen = 1'b1;
    chk(seen, 64'h0);
    // unmapped address is refused
    apb(1'b0, 8'h0c, 32'h0);
    chk({err, q32}, {31'h0, 1'b1, 32'h0});
    // reset in mid-run clears outputs and control
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk({line_valid, line_count_field}, 64'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, TEF_CTRL_OFS, 32'h0);
    chk(q32, 64'h0);
    end_of_test();
  end
endmodule : tef_trace_entry_formatter_tb
